// ### verilog/event_request_pkg.sv
// event request output: shared constants and carrier types
// assumes a single 100 MHz clock domain
package event_request_pkg;

   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int PULSE_US = 100;
   localparam int GAP_US = 100;
   localparam int CFG_FILTER_US = 10;
   localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
   localparam int GAP_CYC = GAP_US * CLK_MHZ;
   localparam int CFG_FILTER_CYC = CFG_FILTER_US * CLK_MHZ;
   localparam int CNT_W = 16;

   // -------------------------------------------------------------
   // status layout
   // -------------------------------------------------------------
   localparam int WAKE_W = 8;
   localparam int FAIL_W = 8;
   localparam logic [WAKE_W-1:0] WAKE_ZERO = 8'h00;
   localparam logic [FAIL_W-1:0] FAIL_ZERO = 8'h00;

   // register port addresses (index of each status word, then the control word)
   localparam logic [1:0] ADDR_WAKE_ONE = 2'h0;
   localparam logic [1:0] ADDR_WAKE_TWO = 2'h1;
   localparam logic [1:0] ADDR_FAIL = 2'h2;
   localparam logic [1:0] ADDR_CTRL = 2'h3;
   localparam int CTRL_GLOBAL_BIT = 0;

   typedef enum logic [1:0] {
      MODE_INIT,
      MODE_NORMAL,
      MODE_STOP,
      MODE_OTHER
   } op_mode_e;

   typedef enum logic [1:0] {
      PH_IDLE,
      PH_PULSE,
      PH_GAP
   } phase_e;

   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

endpackage

// ### verilog/event_status_word.sv
// one sticky status word: raw events gathered, published on commit
// assumes events and clear come from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module event_status_word #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [W-1:0] raw_set,
   input wire logic commit,
   input wire logic clear,
   output logic [W-1:0] shown,
   output logic [W-1:0] pending
);
   typedef struct packed {
      logic [W-1:0] pend;
      logic [W-1:0] shown;
   } word_s;
   word_s s_q, s_d;

   always_comb begin
      s_d = s_q;
      // clear first so a same-cycle event still lands
      if (clear) begin
         s_d.shown = '0;
      end
      if (commit) begin
         s_d.shown = s_d.shown | s_q.pend;
         s_d.pend = '0;
      end
      s_d.pend = s_d.pend | raw_set;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign shown = s_q.shown;
   assign pending = s_q.pend;
endmodule
`default_nettype wire

// ### verilog/event_request_output.sv
// event request output: active-low pulse toward the host controller
// assumes one 100 MHz clock, event inputs are single-cycle same-domain
// pulses, and the request pin is sampled only in init mode
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Function
// - low pulse of fixed width, then release
// - minimum high gap between two pulses
// - pulses never change the operating mode
// - class zero: wake status events only
// - wake pulses need enabled wake source
// - class one adds failures, never level status
// - restart and fail-safe errors never pulse
// - stop entry with uncleared wake status pulses
// - status published on each falling edge
// - events latched until host read-clear
// - init mode samples pin through filter
module event_request_output #(
   parameter int PULSE_CYC = event_request_pkg::PULSE_CYC,
   parameter int GAP_CYC = event_request_pkg::GAP_CYC,
   parameter int CFG_FILTER_CYC = event_request_pkg::CFG_FILTER_CYC
) (
   input wire logic clk,
   input wire logic resetn,
   input wire event_request_pkg::op_mode_e op_mode,
   input wire logic stop_command,
   input wire logic [event_request_pkg::WAKE_W-1:0] wake_one_event,
   input wire logic [event_request_pkg::WAKE_W-1:0] wake_two_event,
   input wire logic [event_request_pkg::WAKE_W-1:0] wake_one_enable,
   input wire logic [event_request_pkg::WAKE_W-1:0] wake_two_enable,
   input wire logic [event_request_pkg::FAIL_W-1:0] fail_event,
   input wire logic [event_request_pkg::FAIL_W-1:0] fail_is_fatal,
   input wire logic [event_request_pkg::WAKE_W-1:0] wake_level_status,
   input wire event_request_pkg::reg_req_s reg_req,
   input wire logic request_pin_in,
   output logic [7:0] reg_rdata,
   output logic request_pin_out,
   output logic request_pin_oe,
   output logic hw_config_sel,
   output logic hw_config_valid
);
   typedef struct packed {
      event_request_pkg::phase_e phase;
      logic [event_request_pkg::CNT_W-1:0] cnt;
      logic pin_low;
      logic global_sel;
      logic [7:0] rdata;
      logic stop_arm;
      logic [1:0] pin_sync;
      logic [event_request_pkg::CNT_W-1:0] flt_cnt;
      logic flt_level;
      logic cfg_sel;
      logic cfg_valid;
   } state_s;

   localparam logic [event_request_pkg::CNT_W-1:0] PULSE_LAST =
      event_request_pkg::CNT_W'(PULSE_CYC - 1);
   localparam logic [event_request_pkg::CNT_W-1:0] GAP_LAST =
      event_request_pkg::CNT_W'(GAP_CYC - 1);
   localparam logic [event_request_pkg::CNT_W-1:0] FLT_LAST =
      event_request_pkg::CNT_W'(CFG_FILTER_CYC - 1);
   localparam logic [event_request_pkg::CNT_W-1:0] CNT_ONE =
      event_request_pkg::CNT_W'(1);

   state_s s_q, s_d;

   // -------------------------------------------------------------
   // event qualification
   // -------------------------------------------------------------
   logic [event_request_pkg::WAKE_W-1:0] w1_raw, w2_raw;
   logic [event_request_pkg::FAIL_W-1:0] f_raw;
   logic [event_request_pkg::WAKE_W-1:0] w1_shown, w2_shown;
   logic [event_request_pkg::WAKE_W-1:0] w1_pend, w2_pend;
   logic [event_request_pkg::FAIL_W-1:0] f_shown, f_pend;
   logic [event_request_pkg::FAIL_W-1:0] f_pulse_mask;
   logic commit;
   logic clr_w1, clr_w2, clr_f;
   logic signalling;
   logic want_pulse;
   logic wake_uncleared;

   // wake events are only recorded for enabled sources
   assign w1_raw = wake_one_event & wake_one_enable;
   assign w2_raw = wake_two_event & wake_two_enable;
   // fatal errors are still recorded, but never request a pulse
   assign f_raw = fail_event;
   assign f_pulse_mask = s_q.global_sel ? ~fail_is_fatal
                                        : event_request_pkg::FAIL_ZERO;

   // read of a status word clears it afterwards
   assign clr_w1 = reg_req.rd &&
                   reg_req.addr == event_request_pkg::ADDR_WAKE_ONE;
   assign clr_w2 = reg_req.rd &&
                   reg_req.addr == event_request_pkg::ADDR_WAKE_TWO;
   assign clr_f = reg_req.rd &&
                  reg_req.addr == event_request_pkg::ADDR_FAIL;

   event_status_word #(
      .W(event_request_pkg::WAKE_W)
   ) u_wake_one (
      .clk(clk),
      .resetn(resetn),
      .raw_set(w1_raw),
      .commit(commit),
      .clear(clr_w1),
      .shown(w1_shown),
      .pending(w1_pend)
   );

   event_status_word #(
      .W(event_request_pkg::WAKE_W)
   ) u_wake_two (
      .clk(clk),
      .resetn(resetn),
      .raw_set(w2_raw),
      .commit(commit),
      .clear(clr_w2),
      .shown(w2_shown),
      .pending(w2_pend)
   );

   event_status_word #(
      .W(event_request_pkg::FAIL_W)
   ) u_fail (
      .clk(clk),
      .resetn(resetn),
      .raw_set(f_raw),
      .commit(commit),
      .clear(clr_f),
      .shown(f_shown),
      .pending(f_pend)
   );

   // pulses only start in normal and stop; mode is an input only,
   // so nothing here can feed back into the mode machine
   assign signalling = op_mode == event_request_pkg::MODE_NORMAL ||
                       op_mode == event_request_pkg::MODE_STOP;

   assign wake_uncleared = (w1_shown | w2_shown | w1_pend | w2_pend)
                           != event_request_pkg::WAKE_ZERO;

   // pending work waits for idle, so it survives pulse and gap
   assign want_pulse = (w1_pend | w2_pend) != event_request_pkg::WAKE_ZERO
                    || (f_pend & f_pulse_mask) != event_request_pkg::FAIL_ZERO
                    || s_q.stop_arm;

   // publish on the cycle the pin goes low
   assign commit = s_q.phase == event_request_pkg::PH_IDLE &&
                   signalling && want_pulse;

   // -------------------------------------------------------------
   // pulse sequencer and config filter
   // -------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.pin_sync = {s_q.pin_sync[0], request_pin_in};
      if (reg_req.wr && reg_req.addr == event_request_pkg::ADDR_CTRL) begin
         s_d.global_sel = reg_req.wdata[event_request_pkg::CTRL_GLOBAL_BIT];
      end
      s_d.rdata = 8'h00;
      if (reg_req.rd) begin
         unique case (reg_req.addr)
            event_request_pkg::ADDR_WAKE_ONE: s_d.rdata = w1_shown;
            event_request_pkg::ADDR_WAKE_TWO: s_d.rdata = w2_shown;
            event_request_pkg::ADDR_FAIL: s_d.rdata = f_shown;
            event_request_pkg::ADDR_CTRL: s_d.rdata = {7'h00, s_q.global_sel};
         endcase
      end
      unique case (s_q.phase)
         event_request_pkg::PH_IDLE: begin
            if (commit) begin
               s_d.phase = event_request_pkg::PH_PULSE;
               s_d.pin_low = 1'b1;
               s_d.cnt = '0;
               s_d.stop_arm = 1'b0;
            end
         end
         event_request_pkg::PH_PULSE: begin
            if (s_q.cnt == PULSE_LAST) begin
               s_d.phase = event_request_pkg::PH_GAP;
               s_d.pin_low = 1'b0;
               s_d.cnt = '0;
            end else begin
               s_d.cnt = s_q.cnt + CNT_ONE;
            end
         end
         event_request_pkg::PH_GAP: begin
            if (s_q.cnt == GAP_LAST) begin
               s_d.phase = event_request_pkg::PH_IDLE;
            end else begin
               s_d.cnt = s_q.cnt + CNT_ONE;
            end
         end
         default: begin
            s_d.phase = event_request_pkg::PH_IDLE;
            s_d.pin_low = 1'b0;
         end
      endcase
      // after the sequencer: a stop command beats the clear at pulse start
      if (stop_command && wake_uncleared) begin
         s_d.stop_arm = 1'b1;
      end
      // init mode: accept a pin level once it held for the filter time
      if (op_mode == event_request_pkg::MODE_INIT) begin
         if (s_q.pin_sync[1] != s_q.flt_level) begin
            s_d.flt_level = s_q.pin_sync[1];
            s_d.flt_cnt = '0;
         end else if (s_q.flt_cnt == FLT_LAST) begin
            s_d.cfg_sel = s_q.flt_level;
            s_d.cfg_valid = 1'b1;
         end else begin
            s_d.flt_cnt = s_q.flt_cnt + CNT_ONE;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   // pin released (input) in init so the strap level can be read;
   // driven high when idle, low while pulsing
   assign request_pin_oe = op_mode != event_request_pkg::MODE_INIT;
   assign request_pin_out = ~s_q.pin_low;
   assign reg_rdata = s_q.rdata;
   assign hw_config_sel = s_q.cfg_sel;
   assign hw_config_valid = s_q.cfg_valid;
endmodule
`default_nettype wire

// ### tb/event_request_output_sva.sv
// checker: request pin timing and register port
// assumes binding into the design with short counts
`timescale 1ns/1ps
`default_nettype none
module event_request_output_sva #(
   parameter int PULSE_CYC = 20,
   parameter int GAP_CYC = 20
) (
   input wire logic clk,
   input wire logic resetn,
   input wire event_request_pkg::op_mode_e op_mode,
   input wire logic [7:0] wake_one_event,
   input wire logic [7:0] wake_one_enable,
   input wire event_request_pkg::reg_req_s reg_req,
   input wire logic [7:0] reg_rdata,
   input wire logic request_pin_out,
   input wire logic request_pin_oe,
   input wire logic hw_config_valid
);
   int low_q;
   int hi_q;
   // high count saturates so the first pulse after reset is legal
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         low_q <= 0;
         hi_q <= GAP_CYC;
      end else if (request_pin_out) begin
         low_q <= 0;
         hi_q <= (hi_q >= GAP_CYC) ? hi_q : hi_q + 1;
      end else begin
         low_q <= low_q + 1;
         hi_q <= 0;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   sequence s_idle_wake;
      op_mode == event_request_pkg::MODE_NORMAL && request_pin_out &&
         hi_q >= GAP_CYC && (wake_one_event & wake_one_enable) != 8'h00;
   endsequence
   sequence s_low_soon;
      ##[1:3] !request_pin_out;
   endsequence
   a_pulse_max: assert property (!request_pin_out |-> low_q < PULSE_CYC)
      else $error("request pulse too long");
   a_pulse_width: assert property ($rose(request_pin_out) |->
      $past(low_q) == PULSE_CYC - 1) else $error("request pulse short");
   a_gap_min: assert property ($fell(request_pin_out) |->
      $past(hi_q) >= GAP_CYC - 1) else $error("gap between pulses short");
   a_pulse_mode: assert property ($fell(request_pin_out) |->
      $past(op_mode) inside {event_request_pkg::MODE_NORMAL,
      event_request_pkg::MODE_STOP}) else $error("pulse in wrong mode");
   a_oe_init: assert property (request_pin_oe ==
      (op_mode != event_request_pkg::MODE_INIT)) else $error("pin drive");
   a_rdata_idle: assert property (!$past(reg_req.rd) |->
      reg_rdata == 8'h00) else $error("read data without read");
   a_cfg_init: assert property ($rose(hw_config_valid) |->
      $past(op_mode) == event_request_pkg::MODE_INIT) else $error("config");
   a_wake_pulse: assert property (s_idle_wake |-> s_low_soon)
      else $error("enabled wake gave no pulse");
endmodule
bind event_request_output event_request_output_sva #(.PULSE_CYC(PULSE_CYC),
   .GAP_CYC(GAP_CYC)) u_event_request_output_sva (.clk, .resetn, .op_mode,
   .wake_one_event, .wake_one_enable, .reg_req, .reg_rdata,
   .request_pin_out, .request_pin_oe, .hw_config_valid);
`default_nettype wire

// ### tb/event_host_model.sv
// host model: register port master and board strap on the pin
// assumes access is called right after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module event_host_model (
   input wire logic clk,
   input wire logic strap_level,
   input wire logic request_pin_out,
   input wire logic request_pin_oe,
   input wire logic [7:0] reg_rdata,
   output var event_request_pkg::reg_req_s reg_req,
   output logic request_pin_in
);
   // undriven in init mode, the board strap sets the level
   assign request_pin_in = request_pin_oe ? request_pin_out : strap_level;
   initial reg_req = '0;
   // one strobe cycle; read data exists in the next cycle only
   task automatic access(input logic [1:0] a, input logic [7:0] wd,
         input logic w, output logic [7:0] d);
      reg_req <= '{addr: a, wdata: wd, wr: w, rd: !w};
      @(posedge clk);
      reg_req <= '0;
      #1;
      d = reg_rdata;
      @(posedge clk);
   endtask
endmodule
`default_nettype wire

// ### tb/event_request_output_tb.sv
// bench: event request block beside the host model
// assumes short pulse, gap and filter counts
`timescale 1ns/1ps
`default_nettype none
module event_request_output_tb;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   event_request_pkg::op_mode_e op_mode = event_request_pkg::MODE_INIT;
   logic stop_cmd = 1'b0;
   logic strap = 1'b1;
   logic [7:0] w1 = 8'h00, w2 = 8'h00, w1en = 8'h04, w2en = 8'h01;
   logic [7:0] fail = 8'h00, fatal = 8'h01, lvl = 8'h00, reg_rdata, k;
   event_request_pkg::reg_req_s reg_req;
   logic request_pin_in, request_pin_out, request_pin_oe;
   logic hw_config_sel, hw_config_valid;
   int n_fail = 0;
   int samples_checked = 0;
   initial forever #5 clk = ~clk;
   event_request_output #(.PULSE_CYC(20), .GAP_CYC(20), .CFG_FILTER_CYC(5))
   u_event_request_output (.clk, .resetn, .op_mode, .stop_command(stop_cmd),
      .wake_one_event(w1), .wake_two_event(w2), .wake_one_enable(w1en),
      .wake_two_enable(w2en), .fail_event(fail), .fail_is_fatal(fatal),
      .wake_level_status(lvl), .reg_req, .request_pin_in, .reg_rdata,
      .request_pin_out, .request_pin_oe, .hw_config_sel, .hw_config_valid);
   event_host_model u_host (.clk, .strap_level(strap), .request_pin_out,
      .request_pin_oe, .reg_rdata, .reg_req, .request_pin_in);
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] exp);
      logic [7:0] d;
      u_host.access(a, 8'h00, 1'b0, d);
      check(d, exp);
   endtask
   task automatic fire(input logic [7:0] a, b, c);
      w1 <= a;
      w2 <= b;
      fail <= c;
      @(posedge clk);
      w1 <= 8'h00;
      w2 <= 8'h00;
      fail <= 8'h00;
   endtask
   // counts falling pin edges, returns on a clock edge
   task automatic pulses(input int n, input logic [7:0] exp);
      logic prev;
      k = 8'h00;
      prev = request_pin_out;
      repeat (n) begin
         @(posedge clk);
         #1;
         if (prev && !request_pin_out) k++;
         prev = request_pin_out;
      end
      @(posedge clk);
      check(k, exp);
   endtask
   task automatic t_config;
      repeat (20) @(posedge clk);
      check({7'h00, request_pin_oe}, 8'h00);
      check({6'h00, hw_config_valid, hw_config_sel}, 8'h03);
      op_mode <= event_request_pkg::MODE_NORMAL;
      @(posedge clk);
   endtask
   task automatic t_wake;
      fire(8'h04, 8'h00, 8'h00);
      pulses(5, 8'h01);
      fire(8'h00, 8'h01, 8'h00);
      pulses(90, 8'h01);
      rd(event_request_pkg::ADDR_WAKE_ONE, 8'h04);
      rd(event_request_pkg::ADDR_WAKE_TWO, 8'h01);
      rd(event_request_pkg::ADDR_WAKE_ONE, 8'h00);
   endtask
   task automatic t_global;
      logic [7:0] d;
      u_host.access(event_request_pkg::ADDR_CTRL, 8'h01, 1'b1, d);
      rd(event_request_pkg::ADDR_CTRL, 8'h01);
      lvl <= 8'hff;
      fire(8'h00, 8'h00, 8'h01);
      pulses(60, 8'h00);
      fire(8'h00, 8'h00, 8'h02);
      pulses(60, 8'h01);
      lvl <= 8'h00;
      rd(event_request_pkg::ADDR_FAIL, 8'h03);
      u_host.access(event_request_pkg::ADDR_CTRL, 8'h00, 1'b1, d);
      fire(8'h10, 8'h00, 8'h02);
      pulses(60, 8'h00);
   endtask
   task automatic t_stop;
      fire(8'h04, 8'h00, 8'h00);
      pulses(60, 8'h01);
      op_mode <= event_request_pkg::MODE_STOP;
      stop_cmd <= 1'b1;
      @(posedge clk);
      stop_cmd <= 1'b0;
      pulses(60, 8'h01);
      check({7'h00, request_pin_oe}, 8'h01);
      op_mode <= event_request_pkg::MODE_OTHER;
      fire(8'h04, 8'h00, 8'h00);
      pulses(60, 8'h00);
   endtask
   task automatic finish_test;
      $display("checks %0d failures %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      t_config();
      t_wake();
      t_global();
      t_stop();
      finish_test();
   end
   // the whole run needs about five hundred cycles
   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      finish_test();
   end
endmodule
`default_nettype wire
